//--- rst_src_pkg.sv
// Constants, field positions and state encoding for the reset source controller
package rst_src_pkg;
    localparam logic [7:0]  RESET_CAUSE_REG_ADDR = 8'hef;
    localparam int          CAUSE_W              = 7;
    localparam int          BIT_PIN              = 0;
    localparam int          BIT_PWR              = 1;
    localparam int          BIT_CLK              = 2;
    localparam int          BIT_WDT              = 3;
    localparam int          BIT_SW               = 4;
    localparam int          BIT_CMP              = 5;
    localparam int          BIT_MEM              = 6;
    localparam logic [6:0]  CAUSE_RESET          = 7'h02;
    localparam logic [6:0]  CAUSE_PIN            = 7'h01;
    localparam logic [6:0]  CAUSE_PWR            = 7'h02;
    localparam logic [6:0]  CAUSE_CLK            = 7'h04;
    localparam logic [6:0]  CAUSE_WDT            = 7'h08;
    localparam logic [6:0]  CAUSE_SW             = 7'h10;
    localparam logic [6:0]  CAUSE_CMP            = 7'h20;
    localparam logic [6:0]  CAUSE_MEM            = 7'h40;
    localparam int          CNT_W                = 16;
    localparam int          CLK_PERIOD_NS        = 50;
    localparam int          POR_DELAY_NS         = 300000;
    localparam int          POR_DELAY_CYC        = (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CLK_LOSS_TIMEOUT_NS  = 100000;
    localparam int          CLK_LOSS_TIMEOUT_CYC = (CLK_LOSS_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          HOLD_CYC             = 8;
    localparam logic [3:0]  WDT_DIV_LAST         = 4'hb;
    localparam logic [1:0]  PIN_GUARD_CYC        = 2'h3;
    localparam logic [15:0] USER_CODE_LIMIT      = 16'h1fff;

    typedef enum logic [2:0] {
        ST_POR  = 3'b001,
        ST_RUN  = 3'b010,
        ST_HOLD = 3'b100
    } seq_state_e;
endpackage

//--- clock_loss_detector.sv
// Retriggerable one-shot that flags a monitored clock stuck high or low
module clock_loss_detector (
    input  wire logic i_clk,     // Sampling clock
    input  wire logic i_resetn,  // Async reset, active low
    input  wire logic i_enable,  // Detector armed
    input  wire logic i_level,   // Synchronised level of the watched clock
    output logic      o_timeout  // One-cycle pulse on timeout
);
    import rst_src_pkg::*;

    logic             prev_q, prev_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic             to_q, to_d;

    always_comb begin
        prev_d = i_level;
        to_d   = 1'b0;
        cnt_d  = cnt_q;
        // Every edge of the watched clock retriggers the one-shot
        if (!i_enable || (i_level != prev_q)) begin
            cnt_d = '0;
        end else if (cnt_q == CNT_W'(CLK_LOSS_TIMEOUT_CYC - 1)) begin
            cnt_d = '0;
            to_d  = 1'b1;
        end else begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            prev_q <= 1'b0;
            cnt_q  <= '0;
            to_q   <= 1'b0;
        end else begin
            prev_q <= prev_d;
            cnt_q  <= cnt_d;
            to_q   <= to_d;
        end
    end

    assign o_timeout = to_q;
endmodule

//--- reset_source_controller.sv
// Reset source collection, cause recording and reset sequencing
// Contract
// - Supply low drives pin and holds core
// - Supply monitor enable survives non-power resets
// - Writing bit 1 enables supply monitor
// - No power-on delay after supply reset
// - Low pin resets; pin flag set
// - Clock-loss one-shot times out to reset
// - Bit 2 enables detector, reads its cause
// - Only power-on and supply resets pull the pin
// - Bit 5 enables comparator reset, reads cause
// - Watchdog restarts enabled, ticking clock/12; flag
// - Program access above limit causes reset
// - Memory-error flag reads one afterwards
// - Writing bit 4 forces reset; flag reads one
// - Power flag set after power resets
// - Other resets clear the power flag
module reset_source_controller
    import rst_src_pkg::*;
#(
    parameter int POR_DELAY_CYCLES = rst_src_pkg::POR_DELAY_CYC
) (
    input  wire logic        i_clk,          // System clock, 20 MHz
    input  wire logic        i_resetn,       // Power-on reset, async, active low
    input  wire logic [7:0]  i_sfr_addr,     // Special-function register address
    input  wire logic        i_sfr_wr,       // Register write strobe
    input  wire logic [7:0]  i_sfr_wdata,    // Register write data
    output logic      [7:0]  o_sfr_rdata,    // Register read data
    input  wire logic        i_supply_below, // Supply below reset threshold
    input  wire logic        i_rst_pin,      // Reset pin level, low asserts
    output logic             o_rst_pin,      // Reset pin drive value
    output logic             o_rst_pin_oe,   // Reset pin drive enable
    input  wire logic        i_system_clock_obs,   // Watched system clock level
    input  wire logic        i_cmp_out,      // Comparator out, low when plus below minus
    input  wire logic        i_wdt_overflow, // Watchdog overflow pulse
    input  wire logic        i_pm_access,    // Program memory access strobe
    input  wire logic [15:0] i_pm_addr,      // Program memory access address
    output logic             o_core_resetn,  // Core reset, active low
    output logic             o_mon_enable,   // Supply monitor enable
    output logic             o_wdt_tick,     // Watchdog clock enable, clock/12
    output logic             o_wdt_defaults  // Pulse: watchdog back to defaults
);
    import rst_src_pkg::*;

    logic [3:0] sync1_q, sync2_q;
    logic       supply_s, pin_s, cmp_s, system_clock_s;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sync1_q <= 4'hb;
            sync2_q <= 4'hb;
        end else begin
            sync1_q <= {i_system_clock_obs, i_supply_below, i_cmp_out, i_rst_pin};
            sync2_q <= sync1_q;
        end
    end
    assign pin_s    = sync2_q[0];
    assign cmp_s    = sync2_q[1];
    assign supply_s = sync2_q[2];
    assign system_clock_s = sync2_q[3];

    seq_state_e       state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [6:0]       cause_q, cause_d;
    logic             mon_en_q, mon_en_d;
    logic             clk_en_q, clk_en_d;
    logic             cmp_en_q, cmp_en_d;
    logic [1:0]       guard_q, guard_d;
    logic [3:0]       div_q, div_d;
    logic             tick_q, tick_d;
    logic             dflt_q, dflt_d;
    logic [7:0]       rdata_q, rdata_d;
    logic             reg_wr, sup_req, pin_req, clk_req, cmp_req, mem_req, sw_req;
    logic             lvl_active, hold_done, clk_timeout, running;

    assign running = (state_q == ST_RUN);
    assign reg_wr  = i_sfr_wr && (i_sfr_addr == RESET_CAUSE_REG_ADDR);

    clock_loss_detector u_clock_loss_detector (
        .i_clk     (i_clk),
        .i_resetn  (i_resetn),
        .i_enable  (clk_en_q && running),
        .i_level   (system_clock_s),
        .o_timeout (clk_timeout)
    );

    // Pin is ignored briefly after we stop driving it, so our own drive is not read back as a pin reset
    assign sup_req    = mon_en_q && supply_s;
    assign pin_req    = !pin_s && (guard_q == 2'h0);
    assign clk_req    = clk_en_q && clk_timeout;
    assign cmp_req    = cmp_en_q && !cmp_s;
    assign mem_req    = i_pm_access && (i_pm_addr > USER_CODE_LIMIT);
    assign sw_req     = reg_wr && i_sfr_wdata[BIT_SW];
    // Pin goes through the guard: our own supply-reset drive must not hold us in reset forever
    assign lvl_active = sup_req || pin_req || cmp_req;
    assign hold_done  = (cnt_q >= CNT_W'(HOLD_CYC - 1));

    always_comb begin
        state_d  = state_q;
        cnt_d    = cnt_q;
        cause_d  = cause_q;
        mon_en_d = mon_en_q;
        clk_en_d = clk_en_q;
        cmp_en_d = cmp_en_q;
        dflt_d   = 1'b0;
        guard_d  = o_rst_pin_oe ? PIN_GUARD_CYC : ((guard_q == 2'h0) ? 2'h0 : guard_q - 2'h1);
        tick_d   = 1'b0;
        div_d    = '0;
        rdata_d  = (i_sfr_addr == RESET_CAUSE_REG_ADDR) ? {1'b0, cause_q} : 8'h00;
        case (state_q)
            ST_POR: begin
                if (cnt_q == CNT_W'(POR_DELAY_CYCLES - 1)) begin
                    state_d = ST_RUN;
                    cnt_d   = '0;
                    dflt_d  = 1'b1;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            ST_RUN: begin
                tick_d = (div_q == WDT_DIV_LAST);
                div_d  = tick_d ? 4'h0 : div_q + 4'h1;
                // Writes store only the enable bits; bit 4 requests a software reset, other read-only cause bits and bit 7 are dropped
                if (reg_wr) begin
                    mon_en_d = i_sfr_wdata[BIT_PWR];
                    clk_en_d = i_sfr_wdata[BIT_CLK];
                    cmp_en_d = i_sfr_wdata[BIT_CMP];
                end
                state_d = ST_HOLD;
                cnt_d   = '0;
                // Highest priority source wins so exactly one flag is captured
                if (sup_req) begin
                    cause_d = CAUSE_PWR;
                end else if (pin_req) begin
                    cause_d = CAUSE_PIN;
                end else if (clk_req) begin
                    cause_d = CAUSE_CLK;
                end else if (cmp_req) begin
                    cause_d = CAUSE_CMP;
                end else if (i_wdt_overflow) begin
                    cause_d = CAUSE_WDT;
                end else if (mem_req) begin
                    cause_d = CAUSE_MEM;
                end else if (sw_req) begin
                    cause_d = CAUSE_SW;
                end else begin
                    state_d = ST_RUN;
                end
            end
            ST_HOLD: begin
                if (!hold_done) begin
                    cnt_d = cnt_q + 1'b1;
                end else if (!lvl_active) begin
                    // Supply resets return straight to run with no power-on delay
                    state_d  = ST_RUN;
                    cnt_d    = '0;
                    dflt_d   = 1'b1;
                    clk_en_d = 1'b0;
                    cmp_en_d = 1'b0;
                end
            end
            default: begin
                state_d = ST_POR;
                cnt_d   = '0;
            end
        endcase
    end

    // Monitor enable is cleared only by the power-on reset below or by a register write with bit 1 low
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q  <= ST_POR;
            cnt_q    <= '0;
            cause_q  <= CAUSE_RESET;
            mon_en_q <= 1'b0;
            clk_en_q <= 1'b0;
            cmp_en_q <= 1'b0;
            guard_q  <= PIN_GUARD_CYC;
            div_q    <= '0;
            tick_q   <= 1'b0;
            dflt_q   <= 1'b0;
            rdata_q  <= 8'h00;
        end else begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            cause_q  <= cause_d;
            mon_en_q <= mon_en_d;
            clk_en_q <= clk_en_d;
            cmp_en_q <= cmp_en_d;
            guard_q  <= guard_d;
            div_q    <= div_d;
            tick_q   <= tick_d;
            dflt_q   <= dflt_d;
            rdata_q  <= rdata_d;
        end
    end

    assign o_sfr_rdata    = rdata_q;
    assign o_core_resetn  = running;
    assign o_rst_pin      = 1'b0;
    assign o_rst_pin_oe   = (state_q == ST_POR) || ((state_q == ST_HOLD) && cause_q[BIT_PWR]);
    assign o_mon_enable   = mon_en_q;
    assign o_wdt_tick     = tick_q;
    assign o_wdt_defaults = dflt_q;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);

    a_supply_pin_drive: assert property (running && sup_req |=> o_rst_pin_oe && !o_core_resetn)
        else $error("supply low did not drive the pin and hold the core");
    a_mon_en_kept: assert property (state_q == ST_HOLD |=> $stable(mon_en_q))
        else $error("supply monitor enable changed across a reset");
    a_mon_en_write: assert property (running && reg_wr && i_sfr_wdata[BIT_PWR] |=> mon_en_q)
        else $error("writing bit 1 did not enable the supply monitor");
    a_supply_no_delay: assert property (state_q == ST_HOLD && cause_q[BIT_PWR] && hold_done && !lvl_active
        |=> running && o_core_resetn)
        else $error("supply reset release was delayed");
    a_pin_cause: assert property (running && pin_req && !sup_req |=> cause_q == CAUSE_PIN ##1 !running)
        else $error("pin reset not recorded");
    a_clk_loss_cause: assert property (running && clk_req && !sup_req && !pin_req |=> cause_q == CAUSE_CLK)
        else $error("clock-loss reset not recorded");
    a_pin_untouched: assert property (state_q == ST_HOLD && !cause_q[BIT_PWR] |-> !o_rst_pin_oe)
        else $error("non-supply reset drove the pin");
    a_cmp_cause: assert property (running && cmp_req && !sup_req && !pin_req && !clk_req
        |=> cause_q == CAUSE_CMP)
        else $error("comparator reset not recorded");
    a_wdt_tick_gap: assert property (tick_q && running ##1 running[*8] |-> !tick_q)
        else $error("watchdog tick came too early");
    a_mem_cause: assert property (running && mem_req && !sup_req && !pin_req && !clk_req && !cmp_req
        && !i_wdt_overflow |=> cause_q == CAUSE_MEM)
        else $error("memory-error reset not recorded");
    a_sw_cause: assert property (running && sw_req && !sup_req && !pin_req && !clk_req && !cmp_req
        && !i_wdt_overflow && !mem_req |=> cause_q == CAUSE_SW ##1 !o_core_resetn)
        else $error("software reset not forced or not recorded");
    a_bit7_zero: assert property (o_sfr_rdata[7] == 1'b0)
        else $error("bit 7 read as one");
    a_one_cause: assert property ($onehot(cause_q))
        else $error("cause flags not one-hot");
endmodule

//--- ext_reset_side.sv
// Far-side model: reset pin wire with pull-up, external reset circuit and the watched clock
module ext_reset_side (
    input  wire logic i_clk,      // System clock
    input  wire logic i_drive,    // Device pin drive value
    input  wire logic i_drive_oe, // Device pin drive enable
    input  wire logic i_press,    // External circuit pulls the pin low
    input  wire logic i_stall,    // Freeze the watched clock
    output logic      o_pin,      // Resolved pin level
    output logic      o_clk_obs   // Watched clock level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_obs_q = 1'b1;
    // Wired-and with a pull-up: a released pin floats high, never holds its last value
    assign o_pin = !(i_drive_oe && !i_drive) && !i_press;
    // Watched clock toggles each cycle; a stall freezes it to trip the detector
    always_ff @(posedge i_clk) begin
        if (!i_stall) begin
            clk_obs_q <= ~clk_obs_q;
        end
    end
    assign o_clk_obs = clk_obs_q;
endmodule

//--- reset_source_controller_test.sv
// Self-checking bench for the reset source controller
module reset_source_controller_test;
    timeunit 1ns;
    timeprecision 1ps;
    import rst_src_pkg::*;
    localparam int POR_CYC = 40;
    logic        i_clk = 0, i_resetn = 0, i_sfr_wr = 0, i_supply_below = 0, i_cmp_out = 1;
    logic        i_wdt_overflow = 0, i_pm_access = 0, press = 0, stall = 0;
    logic [7:0]  i_sfr_addr = 8'hef, i_sfr_wdata = 8'h00;
    logic [15:0] i_pm_addr = 16'h0000;
    logic [7:0]  o_sfr_rdata;
    logic        o_rst_pin, o_rst_pin_oe, o_core_resetn, o_mon_enable, o_wdt_tick, o_wdt_defaults;
    logic        pin_level, clk_obs;
    int          err_total = 0, total_checks = 0, n, k;
    always #25 i_clk = ~i_clk;
    reset_source_controller #(.POR_DELAY_CYCLES(POR_CYC)) i_dut (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr),
        .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata), .i_supply_below(i_supply_below),
        .i_rst_pin(pin_level), .o_rst_pin(o_rst_pin), .o_rst_pin_oe(o_rst_pin_oe), .i_system_clock_obs(clk_obs),
        .i_cmp_out(i_cmp_out), .i_wdt_overflow(i_wdt_overflow), .i_pm_access(i_pm_access),
        .i_pm_addr(i_pm_addr), .o_core_resetn(o_core_resetn), .o_mon_enable(o_mon_enable),
        .o_wdt_tick(o_wdt_tick), .o_wdt_defaults(o_wdt_defaults));
    ext_reset_side i_far (
        .i_clk(i_clk), .i_drive(o_rst_pin), .i_drive_oe(o_rst_pin_oe), .i_press(press),
        .i_stall(stall), .o_pin(pin_level), .o_clk_obs(clk_obs));
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge i_clk);
        #1;
    endtask
    // Bounded wait for the core reset to reach a level; a hang ends the run
    task automatic wait_core(input logic lvl, input int bound, output int cnt);
        cnt = 0;
        while (o_core_resetn !== lvl && cnt < bound) begin
            tick(1);
            cnt++;
        end
        if (o_core_resetn !== lvl) begin
            chk("core reset wait", {7'h0, lvl}, {7'h0, o_core_resetn});
            test_done();
        end
    endtask
    // Direct writes only, never read-modify-write
    task automatic wr(input logic [7:0] d);
        @(posedge i_clk);
        i_sfr_wr    <= 1'b1;
        i_sfr_wdata <= d;
        @(posedge i_clk);
        i_sfr_wr    <= 1'b0;
    endtask
    task automatic pulse(input int which, input logic [15:0] a);
        @(posedge i_clk);
        if (which == 0) i_wdt_overflow <= 1'b1;
        else begin
            i_pm_access <= 1'b1;
            i_pm_addr   <= a;
        end
        @(posedge i_clk);
        i_wdt_overflow <= 1'b0;
        i_pm_access    <= 1'b0;
    endtask
    task automatic expect_reset(input string what, input logic [6:0] cause, input int bound, input logic pin);
        int c;
        wait_core(1'b0, bound, c);
        chk({what, " pin drive"}, {7'h0, pin}, {7'h0, o_rst_pin_oe});
        wait_core(1'b1, 200, c);
        chk({what, " wdt defaults"}, 8'h01, {7'h0, o_wdt_defaults});
        tick(1);
        chk(what, {1'b0, cause}, o_sfr_rdata);
        $display("test %s done", what);
    endtask
    initial begin
        void'($urandom(32'h5a74_31cf));
        tick(4);
        i_resetn <= 1'b1;
        wait_core(1'b1, POR_CYC + 20, n);
        tick(1);
        chk("power-on cause", {1'b0, CAUSE_PWR}, o_sfr_rdata);
        chk("monitor after power-on", 8'h00, {7'h0, o_mon_enable});
        i_sfr_addr <= 8'hef ^ 8'($urandom_range(1, 255));
        tick(2);
        chk("unmapped read", 8'h00, o_sfr_rdata);
        i_sfr_addr <= 8'hef;
        for (n = 0; n < 20 && o_wdt_tick !== 1'b1; n++) tick(1);
        if (o_wdt_tick !== 1'b1) begin
            chk("tick seen", 8'h01, {7'h0, o_wdt_tick});
            test_done();
        end
        tick(1);
        for (n = 1; n < 20 && o_wdt_tick !== 1'b1; n++) tick(1);
        chk("tick period", 8'd12, 8'(n));
        pulse(0, 16'h0000);
        expect_reset("watchdog", CAUSE_WDT, 5, 1'b0);
        wr(8'hc9);
        tick(4);
        chk("read-only write core", 8'h01, {7'h0, o_core_resetn});
        chk("read-only write cause", {1'b0, CAUSE_WDT}, o_sfr_rdata);
        pulse(1, 16'($urandom_range(0, 16'h1fff)));
        tick(4);
        chk("legal fetch", 8'h01, {7'h0, o_core_resetn});
        for (k = 0; k < 8; k++) begin
            case ($urandom_range(0, 2))
                0: begin pulse(0, 16'h0000); expect_reset("watchdog", CAUSE_WDT, 5, 1'b0); end
                1: begin wr(8'h10); expect_reset("software", CAUSE_SW, 5, 1'b0); end
                default: begin
                    pulse(1, 16'($urandom_range(16'h2000, 16'hffff)));
                    expect_reset("illegal fetch", CAUSE_MEM, 5, 1'b0);
                end
            endcase
        end
        press <= 1'b1;
        tick(6);
        press <= 1'b0;
        expect_reset("reset pin", CAUSE_PIN, 5, 1'b0);
        wr(8'h02);
        tick(2);
        chk("monitor enable", 8'h01, {7'h0, o_mon_enable});
        wr(8'h12);
        expect_reset("software", CAUSE_SW, 5, 1'b0);
        chk("monitor kept", 8'h01, {7'h0, o_mon_enable});
        i_supply_below <= 1'b1;
        wait_core(1'b0, 8, n);
        tick(20);
        chk("supply low core", 8'h00, {7'h0, o_core_resetn});
        chk("supply low pin", 8'h01, {7'h0, o_rst_pin_oe});
        chk("supply low pin level", 8'h00, {7'h0, pin_level});
        i_supply_below <= 1'b0;
        wait_core(1'b1, POR_CYC + 20, n);
        chk("no power-on delay", 8'h01, {7'h0, n < POR_CYC});
        tick(1);
        chk("supply cause", {1'b0, CAUSE_PWR}, o_sfr_rdata);
        // Comparator stays high before its reset enable is written
        tick(4);
        wr(8'h22);
        tick(2);
        i_cmp_out <= 1'b0;
        tick(4);
        i_cmp_out <= 1'b1;
        expect_reset("comparator", CAUSE_CMP, 5, 1'b0);
        wr(8'h06);
        tick(50);
        chk("clock alive", 8'h01, {7'h0, o_core_resetn});
        stall <= 1'b1;
        expect_reset("clock loss", CAUSE_CLK, 2100, 1'b0);
        chk("monitor kept clock loss", 8'h01, {7'h0, o_mon_enable});
        stall <= 1'b0;
        i_resetn <= 1'b0;
        tick(2);
        i_resetn <= 1'b1;
        wait_core(1'b1, POR_CYC + 20, n);
        chk("monitor after second power-on", 8'h00, {7'h0, o_mon_enable});
        test_done();
    end
endmodule
